// file: rtl/csc_status_checksum_regs.sv
// module: status read-back registers and control-port write checksum of the codec
`timescale 1ns/1ps
// Function
// - record channel 1..4 power state shows in channel status bits 7..4.
// - playback channel 1..4 power state shows in channel status bits 3..0.
// - mode field bits 7-5 reads 4 while sleep_i is set; codes 0-3, 5 never.
// - mode reads 6 when active with every channel off.
// - mode reads 7 when active with at least one channel on.
// - mode status register reads 0x80 after reset.
// - bit 4 shows the loop being enabled.
// - bit 3 shows microphone bias enabled.
// - bit 2 shows boost enabled.
// - bit 1 set while any record channel is down from an input fault.
// - bit 0 set while all record channels are down from a bias fault.
// - 8-bit checksum updates on every write to any other register, any page.
// - writing the checksum register loads the written byte.
// - channel status register reads 0x00 after reset.
module csc_status_checksum_regs (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       wr_en_i,
   input  wire logic       rd_en_i,
   input  wire logic [7:0] page_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic [3:0] rec_powered_i,
   input  wire logic [3:0] play_powered_i,
   input  wire logic       sleep_i,
   input  wire logic       loop_en_i,
   input  wire logic       mic_bias_en_i,
   input  wire logic       boost_en_i,
   input  wire logic [3:0] rec_fault_pd_i,
   input  wire logic       bias_fault_pd_i,
   output logic      [7:0] rdata_o,
   output logic            rd_valid_o,
   output logic            rd_hit_o,
   output logic      [7:0] chan_status_o,
   output logic      [7:0] mode_status_o,
   output logic      [7:0] checksum_o
);

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   logic       on_page;
   logic       sel_chan;
   logic       sel_mode;
   logic       sel_cksum;
   logic       cksum_load;
   logic       cksum_acc;

   assign on_page    = (page_i == csc_pkg::PAGE_STATUS);
   assign sel_chan   = on_page && (addr_i == csc_pkg::ADDR_CHAN_PWR);
   assign sel_mode   = on_page && (addr_i == csc_pkg::ADDR_MODE_STS);
   assign sel_cksum  = on_page && (addr_i == csc_pkg::ADDR_CKSUM);
   assign cksum_load = wr_en_i && sel_cksum;
   // writes to the status registers still count as writes to other registers
   assign cksum_acc  = wr_en_i && !sel_cksum;

   // ------------------------------------------------------------------
   // live status fields
   // ------------------------------------------------------------------
   logic                  rec1_powered_flag;
   logic                  rec2_powered_flag;
   logic                  rec3_powered_flag;
   logic                  rec4_powered_flag;
   logic                  play1_powered_flag;
   logic                  play2_powered_flag;
   logic                  play3_powered_flag;
   logic                  play4_powered_flag;
   csc_pkg::csc_mode_type device_mode_code;
   logic                  loop_enabled_flag;
   logic                  mic_bias_on_flag;
   logic                  booster_on_flag;
   logic                  input_fault_partial_shutdown;
   logic                  bias_fault_full_shutdown;
   logic [7:0]            write_checksum_value;

   // input vectors carry channel 1 in the top bit, matching the register
   assign rec1_powered_flag  = rec_powered_i[3];
   assign rec2_powered_flag  = rec_powered_i[2];
   assign rec3_powered_flag  = rec_powered_i[1];
   assign rec4_powered_flag  = rec_powered_i[0];
   assign play1_powered_flag = play_powered_i[3];
   assign play2_powered_flag = play_powered_i[2];
   assign play3_powered_flag = play_powered_i[1];
   assign play4_powered_flag = play_powered_i[0];

   assign loop_enabled_flag            = loop_en_i;
   assign mic_bias_on_flag             = mic_bias_en_i;
   assign booster_on_flag              = boost_en_i;
   assign input_fault_partial_shutdown = |rec_fault_pd_i;
   assign bias_fault_full_shutdown     = bias_fault_pd_i;

   csc_mode_enc u_mode (
      .sleep_i  (sleep_i),
      .any_on_i ((|rec_powered_i) || (|play_powered_i)),
      .mode_o   (device_mode_code)
   );

   csc_cksum_acc u_cksum (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .load_i  (cksum_load),
      .acc_i   (cksum_acc),
      .addr_i  (addr_i),
      .data_i  (wdata_i),
      .value_o (write_checksum_value)
   );

   // ------------------------------------------------------------------
   // status registers: resampled every cycle, never written by the host
   // ------------------------------------------------------------------
   logic [7:0] chan_r;
   logic [7:0] chan_nxt;
   logic [7:0] mode_r;
   logic [7:0] mode_nxt;

   always_comb begin
      chan_nxt = {rec1_powered_flag, rec2_powered_flag, rec3_powered_flag, rec4_powered_flag,
                  play1_powered_flag, play2_powered_flag, play3_powered_flag, play4_powered_flag};
      mode_nxt = '0;
      mode_nxt[csc_pkg::MODE_MSB:csc_pkg::MODE_LSB] = device_mode_code;
      mode_nxt[csc_pkg::LOOP_BIT]  = loop_enabled_flag;
      mode_nxt[csc_pkg::MICB_BIT]  = mic_bias_on_flag;
      mode_nxt[csc_pkg::BOOST_BIT] = booster_on_flag;
      mode_nxt[csc_pkg::INFLT_BIT] = input_fault_partial_shutdown;
      mode_nxt[csc_pkg::BFLT_BIT]  = bias_fault_full_shutdown;
   end

   // no write path reaches these flops, so host writes leave them alone
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chan_r <= csc_pkg::RST_CHAN_PWR;
         mode_r <= csc_pkg::RST_MODE_STS;
      end else begin
         chan_r <= chan_nxt;
         mode_r <= mode_nxt;
      end
   end

   // ------------------------------------------------------------------
   // read port
   // ------------------------------------------------------------------
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       rd_valid_r;
   logic       rd_hit_r;
   logic       rd_hit_nxt;

   // read returns the value held before this edge's write
   always_comb begin
      rdata_nxt  = rdata_r;
      rd_hit_nxt = rd_hit_r;
      if (rd_en_i) begin
         rd_hit_nxt = sel_chan || sel_mode || sel_cksum;
         if (sel_chan) begin
            rdata_nxt = chan_r;
         end else if (sel_mode) begin
            rdata_nxt = mode_r;
         end else if (sel_cksum) begin
            rdata_nxt = write_checksum_value;
         end else begin
            rdata_nxt = csc_pkg::RDATA_UNMAPPED;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_r    <= csc_pkg::RDATA_UNMAPPED;
         rd_valid_r <= 1'b0;
         rd_hit_r   <= 1'b0;
      end else begin
         rdata_r    <= rdata_nxt;
         rd_valid_r <= rd_en_i;
         rd_hit_r   <= rd_hit_nxt;
      end
   end

   assign rdata_o       = rdata_r;
   assign rd_valid_o    = rd_valid_r;
   assign rd_hit_o      = rd_hit_r;
   assign chan_status_o = chan_r;
   assign mode_status_o = mode_r;
   assign checksum_o    = write_checksum_value;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   logic started_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         started_r <= 1'b0;
      end else begin
         started_r <= 1'b1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_rec_bits;
      started_r |-> chan_status_o[7:4] == $past(rec_powered_i);
   endproperty
   a_rec_bits: assert property (p_rec_bits) else $error("record power bits wrong");

   property p_play_bits;
      started_r |-> chan_status_o[3:0] == $past(play_powered_i);
   endproperty
   a_play_bits: assert property (p_play_bits) else $error("playback power bits wrong");

   property p_mode_legal;
      mode_status_o[7:5] inside {3'h4, 3'h6, 3'h7};
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("reserved mode code shown");

   property p_mode_sleep;
      sleep_i |=> mode_status_o[7:5] == 3'h4;
   endproperty
   a_mode_sleep: assert property (p_mode_sleep) else $error("sleep not shown as code 4");

   property p_mode_idle;
      (!sleep_i && rec_powered_i == 4'h0 && play_powered_i == 4'h0) |=> mode_status_o[7:5] == 3'h6;
   endproperty
   a_mode_idle: assert property (p_mode_idle) else $error("idle not shown as code 6");

   property p_mode_run;
      (!sleep_i && (rec_powered_i != 4'h0 || play_powered_i != 4'h0)) |=> mode_status_o[7:5] == 3'h7;
   endproperty
   a_mode_run: assert property (p_mode_run) else $error("active channels not shown as code 7");

   property p_reset_vals;
      !started_r |-> (mode_status_o == 8'h80 && chan_status_o == 8'h00);
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("status reset value wrong");

   property p_side_flags;
      started_r |-> mode_status_o[4:2] == {$past(loop_en_i), $past(mic_bias_en_i), $past(boost_en_i)};
   endproperty
   a_side_flags: assert property (p_side_flags) else $error("loop, bias or boost flag wrong");

   property p_in_fault;
      started_r |-> mode_status_o[1] == (|$past(rec_fault_pd_i));
   endproperty
   a_in_fault: assert property (p_in_fault) else $error("input fault flag wrong");

   property p_bias_fault;
      started_r |-> mode_status_o[0] == $past(bias_fault_pd_i);
   endproperty
   a_bias_fault: assert property (p_bias_fault) else $error("bias fault flag wrong");

   property p_cksum_acc;
      (wr_en_i && !(page_i == 8'h00 && addr_i == 8'h7e))
         |=> checksum_o == 8'($past(checksum_o) + $past(addr_i) + $past(wdata_i));
   endproperty
   a_cksum_acc: assert property (p_cksum_acc) else $error("checksum not accumulated");

   property p_cksum_load;
      (wr_en_i && page_i == 8'h00 && addr_i == 8'h7e) |=> checksum_o == $past(wdata_i);
   endproperty
   a_cksum_load: assert property (p_cksum_load) else $error("checksum not loaded");

   property p_cksum_hold;
      !wr_en_i |=> checksum_o == $past(checksum_o);
   endproperty
   a_cksum_hold: assert property (p_cksum_hold) else $error("checksum moved without a write");

   property p_read_status;
      (rd_en_i && page_i == 8'h00 && addr_i == 8'h7a) |=> rd_valid_o && rd_hit_o && rdata_o == $past(mode_status_o);
   endproperty
   a_read_status: assert property (p_read_status) else $error("status read-back wrong");

   property p_rd_valid;
      started_r |-> rd_valid_o == $past(rd_en_i);
   endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("read answer not one cycle after request");

   property p_read_chan;
      (rd_en_i && sel_chan) |=> rd_hit_o && rdata_o == $past(chan_status_o);
   endproperty
   a_read_chan: assert property (p_read_chan) else $error("channel status read-back wrong");

   property p_read_cksum;
      (rd_en_i && sel_cksum) |=> rd_hit_o && rdata_o == $past(checksum_o);
   endproperty
   a_read_cksum: assert property (p_read_cksum) else $error("checksum read-back wrong");

   property p_wr_chan_kept;
      (wr_en_i && (sel_chan || sel_mode)) |=> chan_status_o == {$past(rec_powered_i), $past(play_powered_i)};
   endproperty
   a_wr_chan_kept: assert property (p_wr_chan_kept) else $error("write disturbed channel status");

   property p_wr_mode_kept;
      (wr_en_i && sel_mode) |=> mode_status_o[1:0] == {(|$past(rec_fault_pd_i)), $past(bias_fault_pd_i)};
   endproperty
   a_wr_mode_kept: assert property (p_wr_mode_kept) else $error("write disturbed mode status");

   c_run_mode: cover property (sleep_i ##1 !sleep_i && (rec_powered_i != 4'h0 || play_powered_i != 4'h0)
                               ##1 mode_status_o[7:5] == 3'h7);
   c_load_then_acc: cover property (cksum_load ##[1:8] cksum_acc);
   c_read_cksum: cover property (rd_en_i && sel_cksum ##1 rd_valid_o);
   c_faults: cover property (mode_status_o[1] && mode_status_o[0]);

endmodule

// file: rtl/csc_pkg.sv
// package: register map, field layout, reset values and mode codes of the codec status/checksum bank
package csc_pkg;

   // ------------------------------------------------------------------
   // register map (page and byte offsets on the control port)
   // ------------------------------------------------------------------
   localparam logic [7:0] PAGE_STATUS      = 8'h00;
   localparam logic [7:0] ADDR_CHAN_PWR    = 8'h79;
   localparam logic [7:0] ADDR_MODE_STS    = 8'h7a;
   localparam logic [7:0] ADDR_CKSUM       = 8'h7e;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_CHAN_PWR     = 8'h00;
   localparam logic [7:0] RST_MODE_STS     = 8'h80;
   localparam logic [7:0] RST_CKSUM        = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED   = 8'h00;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int REC_MSB   = 7;
   localparam int REC_LSB   = 4;
   localparam int PLAY_MSB  = 3;
   localparam int PLAY_LSB  = 0;
   localparam int MODE_MSB  = 7;
   localparam int MODE_LSB  = 5;
   localparam int LOOP_BIT  = 4;
   localparam int MICB_BIT  = 3;
   localparam int BOOST_BIT = 2;
   localparam int INFLT_BIT = 1;
   localparam int BFLT_BIT  = 0;

   // ------------------------------------------------------------------
   // mode codes; 0-3 and 5 are never produced
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_SLEEP = 3'h4,
      MODE_IDLE  = 3'h6,
      MODE_RUN   = 3'h7
   } csc_mode_type;

endpackage

// file: rtl/csc_mode_enc.sv
// module: encodes the three-bit device mode code from sleep and channel activity
`timescale 1ns/1ps
module csc_mode_enc (
   input  wire logic                  sleep_i,
   input  wire logic                  any_on_i,
   output csc_pkg::csc_mode_type      mode_o
);

   always_comb begin
      if (sleep_i) begin
         mode_o = csc_pkg::MODE_SLEEP;
      end else if (any_on_i) begin
         mode_o = csc_pkg::MODE_RUN;
      end else begin
         mode_o = csc_pkg::MODE_IDLE;
      end
   end

endmodule

// file: rtl/csc_cksum_acc.sv
// module: 8-bit write checksum, loaded by a direct write, otherwise summing address and data
`timescale 1ns/1ps
module csc_cksum_acc (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       load_i,
   input  wire logic       acc_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] data_i,
   output logic      [7:0] value_o
);

   logic [7:0] sum_r;
   logic [7:0] sum_nxt;

   // modulo-256 wrap is intended: the carry is dropped on purpose
   always_comb begin
      sum_nxt = sum_r;
      if (load_i) begin
         sum_nxt = data_i;
      end else if (acc_i) begin
         sum_nxt = 8'(sum_r + addr_i + data_i);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sum_r <= csc_pkg::RST_CKSUM;
      end else begin
         sum_r <= sum_nxt;
      end
   end

   assign value_o = sum_r;

endmodule

// file: test/csc_host_model.sv
// host side of the control port: issues single-byte register writes and reads
`timescale 1ns/1ps
module csc_host_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   input  wire logic       rd_valid_i,
   input  wire logic       rd_hit_i,
   output logic            wr_en_o,
   output logic            rd_en_o,
   output logic      [7:0] page_o,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o
);
   // ------------------------------------------------------------
   // idle state
   // ------------------------------------------------------------
   initial begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      page_o  = 8'h00;
      addr_o  = 8'h00;
      wdata_o = 8'h00;
   end

   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   // released address and write data are inverted so a stale value never looks valid
   task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      wr_en_o = 1'b1;
      page_o  = p;
      addr_o  = a;
      wdata_o = d;
      @(posedge clk_i);
      #1;
      wr_en_o = 1'b0;
      addr_o  = ~a;
      wdata_o = ~d;
   endtask

   task automatic rd(input logic [7:0] p, input logic [7:0] a, output logic [7:0] d,
                     output logic h, output logic v);
      @(posedge clk_i);
      #1;
      rd_en_o = 1'b1;
      page_o  = p;
      addr_o  = a;
      @(posedge clk_i);
      #1;
      rd_en_o = 1'b0;
      addr_o  = ~a;
      d       = rdata_i;
      h       = rd_hit_i;
      v       = rd_valid_i;
   endtask
endmodule

// file: test/csc_status_checksum_regs_tb.sv
// testbench: status read-back and write checksum of the codec register bank
`timescale 1ns/1ps
module csc_status_checksum_regs_tb;
   logic       clk_i;
   logic       rst_n_i;
   logic       wr_en, rd_en, rd_valid, rd_hit;
   logic [7:0] page, addr, wdata, rdata, chan_sts, mode_sts, cks;
   logic [3:0] rec_pw, play_pw, rec_flt;
   logic       sleep, loop_en, micb, boost, bias_flt;
   logic [7:0] cs, d, e;
   logic       h, v;
   int         n_mismatch = 0;
   int         checks = 0;

   csc_status_checksum_regs DUT (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
      .page_i(page), .addr_i(addr), .wdata_i(wdata),
      .rec_powered_i(rec_pw), .play_powered_i(play_pw), .sleep_i(sleep),
      .loop_en_i(loop_en), .mic_bias_en_i(micb), .boost_en_i(boost),
      .rec_fault_pd_i(rec_flt), .bias_fault_pd_i(bias_flt),
      .rdata_o(rdata), .rd_valid_o(rd_valid), .rd_hit_o(rd_hit),
      .chan_status_o(chan_sts), .mode_status_o(mode_sts), .checksum_o(cks));

   csc_host_model host (
      .clk_i(clk_i), .rdata_i(rdata), .rd_valid_i(rd_valid), .rd_hit_i(rd_hit),
      .wr_en_o(wr_en), .rd_en_o(rd_en), .page_o(page), .addr_o(addr), .wdata_o(wdata));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // expected checksum kept here: direct write loads, anything else adds address and data
   task automatic wrc(input logic [7:0] p, input logic [7:0] a, input logic [7:0] dd);
      host.wr(p, a, dd);
      if (p == 8'h00 && a == 8'h7e)
         cs = dd;
      else
         cs = cs + a + dd;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic hexp);
      host.rd(8'h00, a, d, h, v);
      chk({7'h00, v}, 8'h01);
      chk(d, exp);
      chk({7'h00, h}, {7'h00, hexp});
   endtask

   // status inputs are registered once, so two edges cover the change
   task automatic settle;
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   task automatic summarize;
      if (n_mismatch == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // clock and watchdog
   // ------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   initial begin
      #20000;
      n_mismatch++;
      summarize;
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      rst_n_i = 1'b0;
      {rec_pw, play_pw, rec_flt} = 12'h000;
      {sleep, loop_en, micb, boost, bias_flt} = 5'h10;
      cs = 8'h00;
      repeat (8) @(posedge clk_i);
      #1;
      chk(chan_sts, 8'h00);
      chk(mode_sts, 8'h80);
      chk(cks, 8'h00);
      rst_n_i = 1'b1;
      settle;
      rdc(8'h7a, 8'h80, 1'b1);
      rdc(8'h79, 8'h00, 1'b1);
      sleep = 1'b0;
      settle;
      chk(mode_sts, 8'hc0);
      for (int i = 0; i < 8; i++) begin
         {rec_pw, play_pw} = 8'h80 >> i;
         settle;
         rdc(8'h79, 8'h80 >> i, 1'b1);
         chk(mode_sts, 8'he0);
      end
      sleep = 1'b1;
      settle;
      chk(mode_sts, 8'h80);
      sleep = 1'b0;
      settle;
      chk(mode_sts, 8'he0);
      {rec_pw, play_pw} = 8'h00;
      for (int j = 0; j < 8; j++) begin
         {loop_en, micb, boost, rec_flt, bias_flt} = 8'h80 >> j;
         e = (j < 3) ? (8'h10 >> j) : ((j < 7) ? 8'h02 : 8'h01);
         settle;
         rdc(8'h7a, 8'hc0 | e, 1'b1);
      end
      {loop_en, micb, boost, rec_flt, bias_flt} = 8'h1f;
      settle;
      rdc(8'h7a, 8'hc3, 1'b1);
      {loop_en, micb, boost, rec_flt, bias_flt} = 8'h00;
      settle;
      wrc(8'h00, 8'h7e, 8'hf0);
      rdc(8'h7e, cs, 1'b1);
      wrc(8'h00, 8'h79, 8'h5a);
      wrc(8'h00, 8'h7a, 8'hff);
      wrc(8'h01, 8'h7e, 8'h10);
      wrc(8'h03, 8'h20, 8'hc7);
      chk(cks, cs);
      rdc(8'h79, 8'h00, 1'b1);
      rdc(8'h7a, 8'hc0, 1'b1);
      rdc(8'h7e, cs, 1'b1);
      rdc(8'h50, 8'h00, 1'b0);
      summarize;
   end
endmodule
